// ---- core/tb_lvd_pkg.sv ----
// constants, types and state layout for the time-base / supply-monitor interrupt block
package tb_lvd_pkg;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_PERIOD_NS        = 40;
	localparam int MONITOR_IRQ_DELAY_NS = 15000; // plain default, no figure given
	localparam int MONITOR_IRQ_DELAY_CYC =
		(MONITOR_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] DELAY_CNT_MAX = 10'(MONITOR_IRQ_DELAY_CYC - 1);
	localparam int PERIOD_BASE          = 8;

	// ***************************************************************
	// register offsets (byte addresses) and field positions
	// ***************************************************************
	localparam logic [7:0] OFS_PSC0  = 8'h00;
	localparam logic [7:0] OFS_PSC1  = 8'h04;
	localparam logic [7:0] OFS_TCTL0 = 8'h08;
	localparam logic [7:0] OFS_TCTL1 = 8'h0c;
	localparam logic [7:0] OFS_MONC  = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_ENABS = 8'h18;
	localparam int TB_EN_BIT   = 7;
	localparam int LV_STAT_BIT = 5;
	localparam int LV_EN_BIT   = 4;
	localparam int FLG_TB0     = 0;
	localparam int FLG_TB1     = 1;
	localparam int FLG_LV      = 2;
	localparam int FLG_MF      = 3;
	localparam int GIE_BIT     = 7;
	localparam logic [1:0] SRC_SYS      = 2'h0;
	localparam logic [1:0] SRC_SYS_DIV4 = 2'h1;
	localparam logic [7:0] RST_REG      = 8'h00;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [1:0] {ACK_TB0, ACK_TB1, ACK_MF, ACK_NONE} ack_src_e;

	typedef struct packed {
		logic     ack;   // one-cycle interrupt entry strobe
		ack_src_e src;   // which vector is being entered
		logic     return_from_interrupt;  // interrupt return executed
		logic     ret;   // plain return executed
	} cpu_evt_s;

	typedef struct packed {
		logic [1:0][1:0]  pscSel;
		logic [1:0]       tbEn;
		logic [1:0][2:0]  tbPer;
		logic [1:0][14:0] div;
		logic [1:0]       pre4;
		logic [1:0]       subSync;
		logic             subPrev;
		logic [1:0]       lvSync;
		logic             supply_monitor_enable;
		logic [2:0]       lvdThr;
		logic             lvStat;
		logic [9:0]       lvdCnt;
		logic             lvdDone;
		logic [1:0]       tbF;
		logic             low_voltage_request_flag;
		logic             mfF;
		logic [3:0]       intEn;
		logic             gie;
		logic             wrPend;
		logic             rdPend;
		logic [7:0]       busAddr;
		logic [31:0]      rdata;
		logic             wake;
		logic             pushPc;
	} state_s;

endpackage

// ---- core/timebase_lowvolt_wakeup_irq.sv ----
// time bases, supply monitor, request flags and wake-up logic with an AHB-Lite register slave
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module timebase_lowvolt_wakeup_irq (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 subClkPin,
	input  wire logic                 lowVoltCompPin,
	input  wire logic                 sleepMode,
	input  wire logic                 idleMode,
	input  wire tb_lvd_pkg::cpu_evt_s cpuEvt,
	output logic [2:0]                thresholdSel,
	output logic                      monitorPowerOn,
	output logic [2:0]                irqRequest,
	output logic                      wakeUp,
	output logic                      pushPcOnly
);

	// ***************************************************************
	// helper functions
	// ***************************************************************

	// prescaler tick for a source code; bit 1 high means sub clock
	function automatic logic srcTick(input logic [1:0] sel, input logic d4, input logic sub);
		if (sel[1]) begin
			srcTick = sub;
		end else if (sel == tb_lvd_pkg::SRC_SYS_DIV4) begin
			srcTick = d4;
		end else begin
			srcTick = 1'b1;
		end
	endfunction

	// low (8+code) bits set: the divider has reached the end of its period
	function automatic logic [14:0] periodMask(input logic [2:0] code);
		logic [15:0] one;
		one = 16'h0001 << (tb_lvd_pkg::PERIOD_BASE + int'(code));
		periodMask = 15'(one - 16'h0001);
	endfunction

	// register read view; unimplemented bits read as zero
	function automatic logic [31:0] readVal(input tb_lvd_pkg::state_s st, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			tb_lvd_pkg::OFS_PSC0:  v = {6'h00, st.pscSel[0]};
			tb_lvd_pkg::OFS_PSC1:  v = {6'h00, st.pscSel[1]};
			tb_lvd_pkg::OFS_TCTL0: v = {st.tbEn[0], 4'h0, st.tbPer[0]};
			tb_lvd_pkg::OFS_TCTL1: v = {st.tbEn[1], 4'h0, st.tbPer[1]};
			tb_lvd_pkg::OFS_MONC:  v = {2'h0, st.lvStat, st.supply_monitor_enable, 1'b0, st.lvdThr};
			tb_lvd_pkg::OFS_FLAGS: v = {4'h0, st.mfF, st.low_voltage_request_flag, st.tbF};
			tb_lvd_pkg::OFS_ENABS: v = {st.gie, 3'h0, st.intEn};
			default:               v = 8'h00;
		endcase
		readVal = {24'h000000, v};
	endfunction

	// ***************************************************************
	// state
	// ***************************************************************
	tb_lvd_pkg::state_s s_q;
	tb_lvd_pkg::state_s s_d;
	logic               subTick;
	logic               div4Tick;
	logic [1:0]         tbTick;
	logic [1:0]         ovf;
	logic               lvSet;
	logic               monOn;
	logic               addrPhase;

	// next-state logic for the whole block
	always_comb begin
		s_d       = s_q;
		s_d.wake  = 1'b0;
		s_d.pushPc = 1'b0;
		lvSet     = 1'b0;
		tbTick    = 2'b00;
		ovf       = 2'b00;

		// pins are foreign to clk: two flops before anything looks at them
		s_d.subSync = {s_q.subSync[0], subClkPin};
		s_d.subPrev = s_q.subSync[1];
		s_d.lvSync  = {s_q.lvSync[0], lowVoltCompPin};
		subTick     = s_q.subSync[1] & ~s_q.subPrev;

		// free-running divide-by-four of the system clock
		s_d.pre4 = s_q.pre4 + 2'h1;
		div4Tick = (s_q.pre4 == 2'h3);

		// time-base dividers; select and period are read live, so a change
		// lands on the next prescaler tick without a disable
		for (int i = 0; i < 2; i++) begin
			tbTick[i] = srcTick(s_q.pscSel[i], div4Tick, subTick);
			if (!s_q.tbEn[i]) begin
				s_d.div[i] = 15'h0000;
			end else if (tbTick[i]) begin
				s_d.div[i] = s_q.div[i] + 15'h0001;
			end
			ovf[i] = s_q.tbEn[i] & tbTick[i] &
				((s_q.div[i] & periodMask(s_q.tbPer[i])) == periodMask(s_q.tbPer[i]));
		end

		// supply monitor: powered only when enabled and not asleep
		monOn      = s_q.supply_monitor_enable & ~sleepMode;
		s_d.lvStat = monOn & s_q.lvSync[1];
		// delay restarts on every fall, so chatter near threshold is harmless
		if (!s_q.lvStat) begin
			s_d.lvdCnt  = 10'h000;
			s_d.lvdDone = 1'b0;
		end else if (!s_q.lvdDone) begin
			if (s_q.lvdCnt == tb_lvd_pkg::DELAY_CNT_MAX) begin
				s_d.lvdDone = 1'b1;
				lvSet       = 1'b1;
			end else begin
				s_d.lvdCnt = s_q.lvdCnt + 10'h001;
			end
		end

		// data phase of a write: software may set or clear any flag
		if (s_q.wrPend) begin
			case (s_q.busAddr)
				tb_lvd_pkg::OFS_PSC0:  s_d.pscSel[0] = hwdata[1:0];
				tb_lvd_pkg::OFS_PSC1:  s_d.pscSel[1] = hwdata[1:0];
				tb_lvd_pkg::OFS_TCTL0: begin
					s_d.tbEn[0]  = hwdata[tb_lvd_pkg::TB_EN_BIT];
					s_d.tbPer[0] = hwdata[2:0];
				end
				tb_lvd_pkg::OFS_TCTL1: begin
					s_d.tbEn[1]  = hwdata[tb_lvd_pkg::TB_EN_BIT];
					s_d.tbPer[1] = hwdata[2:0];
				end
				tb_lvd_pkg::OFS_MONC: begin
					s_d.supply_monitor_enable  = hwdata[tb_lvd_pkg::LV_EN_BIT];
					s_d.lvdThr = hwdata[2:0];
				end
				tb_lvd_pkg::OFS_FLAGS: begin
					s_d.tbF = hwdata[1:0];
					s_d.low_voltage_request_flag = hwdata[tb_lvd_pkg::FLG_LV];
					s_d.mfF = hwdata[tb_lvd_pkg::FLG_MF];
				end
				tb_lvd_pkg::OFS_ENABS: begin
					s_d.intEn = hwdata[3:0];
					s_d.gie   = hwdata[tb_lvd_pkg::GIE_BIT];
				end
				default: ;
			endcase
		end

		// interrupt entry: only the program counter is pushed, global enable drops
		if (cpuEvt.ack) begin
			s_d.pushPc = 1'b1;
			s_d.gie    = 1'b0;
			case (cpuEvt.src)
				tb_lvd_pkg::ACK_TB0: s_d.tbF[0] = 1'b0;
				tb_lvd_pkg::ACK_TB1: s_d.tbF[1] = 1'b0;
				tb_lvd_pkg::ACK_MF:  s_d.mfF    = 1'b0;
				default: ;
			endcase
		end
		if (cpuEvt.return_from_interrupt) begin
			s_d.gie = 1'b1;
		end

		// hardware sets come last so a set beats a clear in the same cycle
		s_d.tbF = s_d.tbF | ovf;
		if (lvSet) begin
			s_d.low_voltage_request_flag = 1'b1;
			if (s_q.intEn[tb_lvd_pkg::FLG_LV]) begin
				s_d.mfF = 1'b1;
			end
		end

		// in sleep or idle mode, wake on any flag rise; a flag already high cannot rise again
		s_d.wake = (sleepMode | idleMode) &
			(|({s_d.mfF, s_d.low_voltage_request_flag, s_d.tbF} & ~{s_q.mfF, s_q.low_voltage_request_flag, s_q.tbF}));

		// address phase; read data built from the next state so that a
		// write in the previous data phase is seen without a wait state
		addrPhase  = hsel & hready & htrans[1];
		s_d.wrPend = 1'b0;
		s_d.rdPend = 1'b0;
		if (addrPhase) begin
			s_d.wrPend  = hwrite & (haddr[31:8] == 24'h000000);
			s_d.rdPend  = ~hwrite;
			s_d.busAddr = haddr[7:0];
			s_d.rdata   = 32'h00000000;
			if (!hwrite && haddr[31:8] == 24'h000000) begin
				s_d.rdata = readVal(s_d, haddr[7:0]);
			end
		end
	end

	// single state register; every field resets to zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	// zero-wait slave: always ready, always OKAY
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = s_q.rdata;
	assign thresholdSel   = s_q.lvdThr;
	assign monitorPowerOn = s_q.supply_monitor_enable & ~sleepMode;
	assign wakeUp         = s_q.wake;
	assign pushPcOnly     = s_q.pushPc;
	// requests gated by enables; flags ignore the enables, except mfF, which the low-voltage request sets only when its enable is on
	assign irqRequest[0] = s_q.gie & s_q.intEn[tb_lvd_pkg::FLG_TB0] & s_q.tbF[0];
	assign irqRequest[1] = s_q.gie & s_q.intEn[tb_lvd_pkg::FLG_TB1] & s_q.tbF[1];
	assign irqRequest[2] = s_q.gie & s_q.intEn[tb_lvd_pkg::FLG_MF] & s_q.mfF;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_DIV4_SOURCE: assert property (
		s_q.tbEn[0] && s_d.tbEn[0] && s_q.pscSel[0] == tb_lvd_pkg::SRC_SYS_DIV4
		&& s_q.pre4 != 2'h3 |=> s_q.div[0] == $past(s_q.div[0]))
		else $error("divide-by-four source advanced off its tick");
	AST_TB0_DISABLED: assert property (
		!s_q.tbEn[0] [*2] |-> s_q.div[0] == 15'h0000 && !ovf[0])
		else $error("disabled time base 0 is counting");
	AST_TB0_PERIOD: assert property (
		s_q.tbEn[0] && s_q.pscSel[0] == tb_lvd_pkg::SRC_SYS && s_q.tbPer[0] == 3'h0
		&& s_q.div[0][7:0] == 8'hff |=> s_q.tbF[0])
		else $error("time base 0 missed its 2^8 overflow");
	AST_TB1_PERIOD: assert property (
		s_q.tbEn[1] && s_q.pscSel[1] == tb_lvd_pkg::SRC_SYS && s_q.tbPer[1] == 3'h1
		&& s_q.div[1][8:0] != 9'h1ff |-> !ovf[1])
		else $error("time base 1 overflowed early");
	AST_RESERVED_ZERO: assert property (
		$past(s_d.rdPend) && $past(s_d.busAddr) == tb_lvd_pkg::OFS_MONC
		|-> hrdata[31:6] == 26'h0 && hrdata[3] == 1'b0)
		else $error("reserved monitor bits read nonzero");
	AST_WAKE_ON_RISE: assert property (
		(sleepMode || idleMode) && !s_q.tbF[0] && ovf[0] |=> wakeUp)
		else $error("flag rise did not wake");
	AST_FLAG_HOLDS: assert property (
		s_q.tbF[1] && !cpuEvt.ack && !s_q.wrPend |=> s_q.tbF[1])
		else $error("time base 1 flag dropped by itself");
	AST_MF_ONLY: assert property (
		cpuEvt.ack && cpuEvt.src == tb_lvd_pkg::ACK_MF && s_q.low_voltage_request_flag && !s_q.wrPend
		|=> s_q.low_voltage_request_flag && pushPcOnly)
		else $error("grouped source flag cleared on service");
	AST_RETURN_GIE: assert property (
		cpuEvt.ret && !cpuEvt.return_from_interrupt && !s_q.gie && !s_q.wrPend |=> !s_q.gie)
		else $error("plain return raised the global enable");
	AST_SLEEP_OFF: assert property (
		sleepMode |=> !s_q.lvStat)
		else $error("monitor active during sleep");
	AST_LV_DELAY: assert property (
		lvSet |-> s_q.lvStat && s_q.lvdCnt == tb_lvd_pkg::DELAY_CNT_MAX)
		else $error("low-voltage request before its delay");
	AST_SERVICE_CLR: assert property (
		cpuEvt.ack && cpuEvt.src == tb_lvd_pkg::ACK_TB0 && !ovf[0] && !cpuEvt.return_from_interrupt
		&& !s_q.wrPend |=> !s_q.tbF[0] && !s_q.gie)
		else $error("time base 0 service did not clear");

	COV_TB0_OVF: cover property (s_q.tbEn[0] && ovf[0]);
	COV_LV_FLAG: cover property ($rose(s_q.low_voltage_request_flag));
	COV_WAKE:    cover property (wakeUp);
	COV_SERVICE: cover property (cpuEvt.ack ##[1:12] cpuEvt.return_from_interrupt);

endmodule

// ---- test/timebase_lowvolt_wakeup_irq_tb_top.sv ----
// self-checking bench for the time-base / supply-monitor interrupt block
`timescale 1ns/10ps
module timebase_lowvolt_wakeup_irq_tb_top;
	// ***************************************************************
	// signals
	// ***************************************************************
	logic                 clk, resetN, hsel, hwrite, hreadyout, hresp, rdPhase;
	logic                 lowVoltCompPin, sleepMode, idleMode, subClkPin = 1'b0;
	logic                 monitorPowerOn, wakeUp, pushPcOnly;
	logic [31:0]          haddr, hwdata, hrdata, d;
	logic [1:0]           htrans;
	logic [2:0]           hsize, thresholdSel, irqRequest, thr;
	tb_lvd_pkg::cpu_evt_s cpuEvt;
	logic [31:0]          rdQ[$];
	logic [1:0]           evQ[$];
	logic [31:0]          mask[5] = '{32'h03, 32'h03, 32'h87, 32'h87, 32'h17};
	int                   nFail = 0, numChecks = 0, cyc = 0, seed = 74, subCnt = 0;

	timebase_lowvolt_wakeup_irq uut (
		.clk(clk), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .subClkPin(subClkPin),
		.lowVoltCompPin(lowVoltCompPin), .sleepMode(sleepMode), .idleMode(idleMode),
		.cpuEvt(cpuEvt), .thresholdSel(thresholdSel), .monitorPowerOn(monitorPowerOn),
		.irqRequest(irqRequest), .wakeUp(wakeUp), .pushPcOnly(pushPcOnly));

	// ***************************************************************
	// clocks, sub clock and hang guard
	// ***************************************************************
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// sub clock rises every ten system clocks, far slower than the sync stages
	always @(posedge clk) begin
		subCnt <= (subCnt == 4) ? 0 : subCnt + 1;
		if (subCnt == 4) subClkPin <= ~subClkPin;
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			nFail++;
			results();
		end
	end

	// ***************************************************************
	// checking
	// ***************************************************************
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// watcher: sampled in the active region, so registered outputs show pre-edge values
	always @(posedge clk) begin
		if (rdPhase === 1'b1) chk("hrdata", hrdata, rdQ.pop_front());
		if (resetN && (wakeUp !== 1'b0 || pushPcOnly !== 1'b0)) begin
			chk("wake/push pulse", 32'({wakeUp, pushPcOnly}), evQ.size() ? evQ.pop_front() : 2'h0);
		end
	end

	// ***************************************************************
	// drivers: every task is entered just after a rising edge
	// ***************************************************************
	task ahb(input logic [7:0] a, input logic w, input logic [31:0] dat);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= dat;
		rdPhase <= ~w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdPhase <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] dat);
		ahb(a, 1'b1, dat);
	endtask

	// the expected value is noted before the read starts
	task rd(input logic [7:0] a, input logic [31:0] e);
		rdQ.push_back(e);
		ahb(a, 1'b0, 32'h0);
	endtask

	task waitc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task cpu(input logic a, input tb_lvd_pkg::ack_src_e s, input logic ri, input logic r);
		cpuEvt <= '{a, s, ri, r};
		@(posedge clk);
		cpuEvt <= '{1'b0, tb_lvd_pkg::ACK_NONE, 1'b0, 1'b0};
		@(posedge clk);
	endtask

	// period check: no flag at nine tenths of the period, flag by eleven tenths
	task tbRun(input int n, input logic [1:0] sel, input logic [2:0] code, input int tick);
		int per;
		per = (256 << code) * tick;
		wr(n ? tb_lvd_pkg::OFS_PSC1 : tb_lvd_pkg::OFS_PSC0, {30'h0, sel});
		wr(n ? tb_lvd_pkg::OFS_TCTL1 : tb_lvd_pkg::OFS_TCTL0, {29'h10, code});
		waitc(per * 9 / 10);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h0);
		waitc(per / 5);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h1 << n);
		wr(n ? tb_lvd_pkg::OFS_TCTL1 : tb_lvd_pkg::OFS_TCTL0, 32'h0);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h1 << n);
		wr(tb_lvd_pkg::OFS_FLAGS, 32'h0);
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		{hwrite, rdPhase, lowVoltCompPin, sleepMode, idleMode} = 5'h0;
		hsel = 1'b1;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		cpuEvt = '{1'b0, tb_lvd_pkg::ACK_NONE, 1'b0, 1'b0};
		resetN = 1'b0;
		waitc(16);
		resetN <= 1'b1;
		waitc(1);
		chk("hresp", 32'(hresp), 32'h0);
		// reset values, unmapped word included
		for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
		// random writes: unimplemented and read-only bits must come back zero
		for (int i = 0; i < 5; i++) begin
			d = $random(seed);
			wr(8'(4 * i), d);
			rd(8'(4 * i), d & mask[i]);
			wr(8'(4 * i), 32'h0);
		end
		wr(8'h1c, d);
		rd(8'h1c, 32'h0);
		wr(tb_lvd_pkg::OFS_FLAGS, 32'h0);
		// divide-by-four source on time base 0 first; the loop leaves it on the system clock
		tbRun(0, 2'h1, 3'h0, 4);
		for (int c = 0; c < 8; c++) tbRun(0, 2'h0, 3'(c), 1);
		tbRun(1, 2'h0, 3'h1, 1);
		tbRun(1, 2'h1, 3'h0, 4);
		tbRun(1, 2'h2, 3'h0, 10);
		tbRun(1, 2'h3, 3'h0, 10);
		// servicing a time-base request
		wr(tb_lvd_pkg::OFS_ENABS, 32'h83);
		wr(tb_lvd_pkg::OFS_TCTL0, 32'h80);
		waitc(270);
		wr(tb_lvd_pkg::OFS_TCTL0, 32'h0);
		chk("irqRequest", 32'(irqRequest), 32'h1);
		evQ.push_back(2'h1);
		// the service routine below executes a plain return before its interrupt return
		cpu(1'b1, tb_lvd_pkg::ACK_TB0, 1'b0, 1'b0);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h0);
		rd(tb_lvd_pkg::OFS_ENABS, 32'h03);
		cpu(1'b0, tb_lvd_pkg::ACK_NONE, 1'b0, 1'b1);
		rd(tb_lvd_pkg::OFS_ENABS, 32'h03);
		cpu(1'b0, tb_lvd_pkg::ACK_NONE, 1'b1, 1'b0);
		rd(tb_lvd_pkg::OFS_ENABS, 32'h83);
		// low supply: status at once, request only after the fixed delay
		thr = 3'($random(seed));
		wr(tb_lvd_pkg::OFS_ENABS, 32'h8c);
		wr(tb_lvd_pkg::OFS_MONC, {27'h2, thr});
		lowVoltCompPin <= 1'b1;
		// let the detector settle before trusting its status bit
		waitc(5);
		chk("thresholdSel", 32'(thresholdSel), 32'(thr));
		chk("monitorPowerOn", 32'(monitorPowerOn), 32'h1);
		rd(tb_lvd_pkg::OFS_MONC, {27'h6, thr});
		waitc(340);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h0);
		waitc(60);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h0c);
		chk("irqRequest", 32'(irqRequest), 32'h4);
		evQ.push_back(2'h1);
		cpu(1'b1, tb_lvd_pkg::ACK_MF, 1'b0, 1'b0);
		rd(tb_lvd_pkg::OFS_FLAGS, 32'h04);
		sleepMode <= 1'b1;
		waitc(5);
		chk("monitorPowerOn", 32'(monitorPowerOn), 32'h0);
		rd(tb_lvd_pkg::OFS_MONC, {27'h2, thr});
		sleepMode <= 1'b0;
		lowVoltCompPin <= 1'b0;
		wr(tb_lvd_pkg::OFS_MONC, 32'h0);
		waitc(1);
		chk("monitorPowerOn", 32'(monitorPowerOn), 32'h0);
		// wake: a flag already high blocks its source, a fresh rise wakes
		wr(tb_lvd_pkg::OFS_FLAGS, 32'h01);
		idleMode <= 1'b1;
		wr(tb_lvd_pkg::OFS_TCTL0, 32'h80);
		waitc(300);
		evQ.push_back(2'h2);
		wr(tb_lvd_pkg::OFS_FLAGS, 32'h0);
		waitc(300);
		wr(tb_lvd_pkg::OFS_TCTL0, 32'h0);
		idleMode <= 1'b0;
		waitc(2);
		chk("pending pulses", 32'(evQ.size()), 32'h0);
		// a fresh low-voltage request wakes from idle once its delay has run
		idleMode <= 1'b1;
		wr(tb_lvd_pkg::OFS_MONC, 32'h10);
		lowVoltCompPin <= 1'b1;
		evQ.push_back(2'h2);
		waitc(400);
		idleMode <= 1'b0;
		lowVoltCompPin <= 1'b0;
		chk("idle wake", 32'(evQ.size()), 32'h0);
		results();
	end
endmodule
